/* conv_pkg.sv */
// constants shared by the converter end and the controller end
// assumes a single 100 MHz clock on both ends
package conv_pkg;
	localparam int CLK_MHZ        = 100;
	localparam int CLK_PERIOD_NS  = 1000 / CLK_MHZ;
	localparam int CONV_PULSE_NS  = 40;
	localparam int BUSY_MAX_NS    = 2000;
	localparam int ACQ_MIN_NS     = 2000;
	localparam int CYCLE_MIN_NS   = 4000;
	localparam int PREV_VALID_NS  = 1500;
	localparam int SETUP_DATA_NS  = 35;
	// least times round up, longest times round down
	localparam int CONV_PULSE_CYC = (CONV_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_MAX_CYC   = BUSY_MAX_NS / CLK_PERIOD_NS;
	localparam int ACQ_MIN_CYC    = (ACQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYCLE_MIN_CYC  = (CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PREV_VALID_CYC = (PREV_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_DATA_CYC = (SETUP_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DATA_W         = 16;
	localparam int HALF_W         = 8;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [15:0] POS_FULL     = 16'h7FFF;
	localparam logic [15:0] NEG_FULL     = 16'h8000;
	localparam int CNT_W          = 12;
endpackage : conv_pkg

/* conv_if.sv */
// pins between the converter and its controller
// assumes the testbench resolves the result bus from the enable
`timescale 1ns/1ps
`default_nettype none
interface conv_if;
	logic        sel_n;
	logic        rd_conv;
	logic        half_sel;
	logic        busy_n;
	logic [7:0]  result_bus_o;
	logic        result_bus_oe;
	logic [7:0]  result_bus_i;
	modport converter (input sel_n, input rd_conv, input half_sel,
		output busy_n, output result_bus_o, output result_bus_oe);
	modport controller (output sel_n, output rd_conv, output half_sel,
		input busy_n, input result_bus_i);
endinterface : conv_if
`default_nettype wire

/* conv_converter.sv */
// converter end: conversion sequencing, busy, three-state result port
// assumes pins synchronous to CLK; samples arrive from a user stream
`timescale 1ns/1ps
`default_nettype none
module conv_converter #(
	parameter int CONV_CYC = conv_pkg::BUSY_MAX_CYC
) (
	input  wire logic        CLK,
	input  wire logic        ARST_N,
	conv_if.converter        PINS,
	input  wire logic [15:0] SAMPLE_DATA,
	output logic             SAMPLE_REQ
);
	if (CONV_CYC < conv_pkg::PREV_VALID_CYC + conv_pkg::SETUP_DATA_CYC + 1 ||
		CONV_CYC > conv_pkg::BUSY_MAX_CYC) begin : g_bad_conv_cyc
		$error("CONV_CYC out of range");
	end

	typedef enum logic [1:0] {IDLE, CONVERT, ABORT_WAIT} state_type;

	state_type   state_reg, state_next;
	logic [conv_pkg::CNT_W-1:0] cnt_reg, cnt_next;
	logic [conv_pkg::CNT_W-1:0] low_reg, low_next;
	logic [15:0] result_reg, result_next;
	logic [15:0] hold_reg, hold_next;
	logic        busy_n_reg, busy_n_next;
	logic        start_low;

	////////////////////////////////////////////////////////////////
	assign start_low = !PINS.sel_n && !PINS.rd_conv;

	always_comb begin
		state_next  = state_reg;
		cnt_next    = cnt_reg;
		low_next    = start_low ? low_reg + 1'b1 : '0;
		result_next = result_reg;
		hold_next   = hold_reg;
		busy_n_next = busy_n_reg;
		SAMPLE_REQ  = 1'b0;
		if (low_reg == conv_pkg::CNT_W'(conv_pkg::CNT_W'(4095)))
			low_next = low_reg;
		case (state_reg)
			IDLE: begin
				// start after low held long enough
				if (start_low && low_reg == conv_pkg::CNT_W'(conv_pkg::CONV_PULSE_CYC - 1)) begin
					state_next  = CONVERT;
					cnt_next    = '0;
					busy_n_next = 1'b0;
					hold_next   = SAMPLE_DATA;
					SAMPLE_REQ  = 1'b1;
				end
			end
			CONVERT: begin
				cnt_next = cnt_reg + 1'b1;
				// result updated ahead of busy rising
				if (cnt_reg == conv_pkg::CNT_W'(CONV_CYC - conv_pkg::SETUP_DATA_CYC - 1))
					result_next = hold_reg;
				// busy never low beyond the maximum
				if (cnt_reg == conv_pkg::CNT_W'(CONV_CYC - 1)) begin
					state_next  = IDLE;
					busy_n_next = 1'b1;
				end
				// fresh low pulse during busy aborts
				if (start_low && low_reg == conv_pkg::CNT_W'(conv_pkg::CONV_PULSE_CYC - 1) &&
					cnt_reg >= conv_pkg::CNT_W'(conv_pkg::CONV_PULSE_CYC)) begin
					state_next  = ABORT_WAIT;
					busy_n_next = 1'b1;
				end
			end
			ABORT_WAIT: begin
				// wait for release before a new start
				if (!start_low)
					state_next = IDLE;
			end
			default: state_next = IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_reg  <= IDLE;
			cnt_reg    <= '0;
			low_reg    <= '0;
			result_reg <= conv_pkg::RESULT_RESET;
			hold_reg   <= conv_pkg::RESULT_RESET;
			busy_n_reg <= 1'b1;
		end else begin
			state_reg  <= state_next;
			cnt_reg    <= cnt_next;
			low_reg    <= low_next;
			result_reg <= result_next;
			hold_reg   <= hold_next;
			busy_n_reg <= busy_n_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// old result stays until update, beyond 1.5 us
	assign PINS.busy_n        = busy_n_reg;
	assign PINS.result_bus_oe = !PINS.sel_n && PINS.rd_conv;
	assign PINS.result_bus_o  = PINS.half_sel ? result_reg[15:8]
		: result_reg[7:0];
endmodule : conv_converter
`default_nettype wire

/* conv_controller.sv */
// controller end: issues conversions, reads both halves into a buffer
// assumes the converter end on the same clock
`timescale 1ns/1ps
`default_nettype none
module conv_controller (
	input  wire logic        CLK,
	input  wire logic        ARST_N,
	conv_if.controller       PINS,
	input  wire logic        START,
	input  wire logic        ABORT,
	output logic             START_READY,
	output logic [15:0]      OUT_DATA,
	output logic             OUT_VALID,
	input  wire logic        OUT_READY
);
	typedef enum logic [2:0] {IDLE, PULSE, WAIT_BUSY, READ_LO, READ_HI, PUSH,
		SPACE} state_type;

	state_type   state_reg, state_next;
	logic [conv_pkg::CNT_W-1:0] cnt_reg, cnt_next;
	logic [conv_pkg::CNT_W-1:0] gap_reg, gap_next;
	logic [7:0]  lo_reg, lo_next;
	logic [15:0] buf0_reg, buf0_next, buf1_reg, buf1_next;
	logic [1:0]  fill_reg, fill_next;
	logic        rd_reg, rd_next, half_reg, half_next;
	logic        abort_reg, abort_next;
	logic        in_valid, in_ready;

	////////////////////////////////////////////////////////////////
	// two-entry buffer keeps words while the user stalls
	assign in_ready  = fill_reg != 2'd2;
	assign OUT_VALID = fill_reg != 2'd0;
	assign OUT_DATA  = buf0_reg;
	assign in_valid  = state_reg == PUSH;

	always_comb begin
		buf0_next = buf0_reg;
		buf1_next = buf1_reg;
		fill_next = fill_reg;
		if (OUT_VALID && OUT_READY) begin
			buf0_next = buf1_reg;
			fill_next = fill_next - 2'd1;
		end
		if (in_valid && in_ready) begin
			if (fill_next == 2'd0)
				buf0_next = {PINS.result_bus_i, lo_reg};
			else
				buf1_next = {PINS.result_bus_i, lo_reg};
			fill_next = fill_next + 2'd1;
		end
	end

	////////////////////////////////////////////////////////////////
	assign START_READY = state_reg == IDLE && gap_reg == '0;

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg + 1'b1;
		gap_next   = gap_reg == '0 ? gap_reg : gap_reg - 1'b1;
		lo_next    = lo_reg;
		rd_next    = rd_reg;
		half_next  = half_reg;
		abort_next = abort_reg;
		case (state_reg)
			IDLE: begin
				// spacing counted in rounded-up cycles
				if ((START || ABORT) && gap_reg == '0) begin
					state_next = PULSE;
					rd_next    = 1'b0;
					cnt_next   = '0;
					gap_next   = conv_pkg::CNT_W'(conv_pkg::CYCLE_MIN_CYC);
					abort_next = ABORT;
				end
			end
			PULSE: begin
				if (cnt_reg == conv_pkg::CNT_W'(conv_pkg::CONV_PULSE_CYC)) begin
					rd_next    = 1'b1;
					abort_next = 1'b0;
					state_next = abort_reg ? SPACE : WAIT_BUSY;
					if (abort_reg)
						gap_next = conv_pkg::CNT_W'(conv_pkg::CYCLE_MIN_CYC);
				end
			end
			WAIT_BUSY: begin
				// no reads until busy returns high
				if (PINS.busy_n && cnt_reg > conv_pkg::CNT_W'(conv_pkg::CONV_PULSE_CYC + 2)) begin
					half_next  = 1'b0;
					state_next = READ_LO;
				end
				// abort request while busy
				if (ABORT && !PINS.busy_n) begin
					state_next = PULSE;
					rd_next    = 1'b0;
					cnt_next   = '0;
					abort_next = 1'b1;
				end
			end
			READ_LO: begin
				lo_next    = PINS.result_bus_i;
				half_next  = 1'b1;
				state_next = READ_HI;
			end
			READ_HI: state_next = PUSH;
			PUSH: begin
				if (in_ready)
					state_next = IDLE;
			end
			SPACE: begin
				// after abort hold high a full cycle time
				if (gap_reg == '0)
					state_next = IDLE;
			end
			default: state_next = IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_reg <= IDLE;
			cnt_reg   <= '0;
			gap_reg   <= '0;
			lo_reg    <= 8'h00;
			buf0_reg  <= 16'h0000;
			buf1_reg  <= 16'h0000;
			fill_reg  <= 2'd0;
			rd_reg    <= 1'b1;
			half_reg  <= 1'b0;
			abort_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			gap_reg   <= gap_next;
			lo_reg    <= lo_next;
			buf0_reg  <= buf0_next;
			buf1_reg  <= buf1_next;
			fill_reg  <= fill_next;
			rd_reg    <= rd_next;
			half_reg  <= half_next;
			abort_reg <= abort_next;
		end
	end

	assign PINS.sel_n    = 1'b0;
	assign PINS.rd_conv  = rd_reg;
	assign PINS.half_sel = half_reg;
endmodule : conv_controller
`default_nettype wire

/* conv_props.sv */
// pin checker for the converter link
// assumes one clock, placed beside conv_if
`timescale 1ns/1ps
`default_nettype none
module conv_props #(
	parameter int CONV_CYC = conv_pkg::BUSY_MAX_CYC
) (
	input wire logic       CLK,
	input wire logic       ARST_N,
	input wire logic       sel_n,
	input wire logic       rd_conv,
	input wire logic       half_sel,
	input wire logic       busy_n,
	input wire logic [7:0] result_bus_o,
	input wire logic       result_bus_oe
);
	logic [11:0] low_reg;
	logic [11:0] gap_reg;
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			low_reg <= 12'h000;
			gap_reg <= 12'hFFF;
		end else begin
			low_reg <= busy_n ? 12'h000 : low_reg + 12'h001;
			if ($fell(busy_n))
				gap_reg <= 12'h001;
			else if (gap_reg != 12'hFFF)
				gap_reg <= gap_reg + 12'h001;
		end
	end
	////////////////////////////////////////////////////////////////////////
	sequence conv_low; !$past(rd_conv, 1) && !$past(rd_conv, 4); endsequence
	sequence busy_run; !busy_n [*4]; endsequence
	sequence abort_low;
		(!busy_n && !rd_conv && low_reg > 12'h004) [*4];
	endsequence
	AST_OE: assert property (result_bus_oe == (!sel_n && rd_conv))
		else $error("bus enable wrong");
	AST_SEL: assert property (sel_n == 1'b0)
		else $error("select not held low");
	AST_START: assert property ($fell(busy_n) |-> conv_low)
		else $error("busy fell without convert pulse");
	AST_RUN: assert property ($fell(busy_n) |-> busy_run)
		else $error("busy pulse too short");
	AST_MAX: assert property (!busy_n |-> low_reg < CONV_CYC)
		else $error("busy low too long");
	AST_PREV: assert property (!busy_n && !$past(busy_n) &&
		$stable(half_sel) && low_reg < conv_pkg::PREV_VALID_CYC
		|-> $stable(result_bus_o)) else $error("old result lost early");
	AST_SETUP: assert property ($rose(busy_n) &&
		$past(half_sel, 4) == half_sel
		|-> $past(result_bus_o, 4) == result_bus_o)
		else $error("result late before busy rise");
	AST_GAP: assert property ($fell(busy_n) |->
		gap_reg >= conv_pkg::CYCLE_MIN_CYC) else $error("starts too close");
	AST_ABORT: assert property (abort_low |-> ##[1:3] busy_n)
		else $error("abort ignored");
endmodule : conv_props
`default_nettype wire

/* tb_sar_adc_parallel_read_convert_ctrl.sv */
// bench joining both ends through conv_if
// assumes package, interface and both ends compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_parallel_read_convert_ctrl;
	logic        clk;
	logic        arst_n;
	logic [15:0] sample_data;
	logic        start;
	logic        abort;
	logic        start_ready;
	logic [15:0] out_data;
	logic        out_valid;
	logic        out_ready;
	logic [7:0]  last_bus;
	int          fail_count;
	int          comparisons;
	conv_if pins ();
	assign pins.result_bus_i = pins.result_bus_oe ?
		pins.result_bus_o : ~last_bus;
	always @(posedge clk) if (pins.result_bus_oe) last_bus <= pins.result_bus_o;
	conv_converter #(.CONV_CYC(200)) u_conv_converter (.CLK(clk),
		.ARST_N(arst_n), .PINS(pins), .SAMPLE_DATA(sample_data),
		.SAMPLE_REQ());
	conv_controller u_conv_controller (.CLK(clk), .ARST_N(arst_n),
		.PINS(pins), .START(start), .ABORT(abort),
		.START_READY(start_ready), .OUT_DATA(out_data),
		.OUT_VALID(out_valid), .OUT_READY(out_ready));
	conv_props #(.CONV_CYC(200)) u_conv_props (.CLK(clk), .ARST_N(arst_n),
		.sel_n(pins.sel_n), .rd_conv(pins.rd_conv),
		.half_sel(pins.half_sel), .busy_n(pins.busy_n),
		.result_bus_o(pins.result_bus_o),
		.result_bus_oe(pins.result_bus_oe));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	task automatic wait_for(input bit out_side);
		int n;
		n = 0;
		while ((out_side ? out_valid : start_ready) !== 1'b1 && n < 900) begin
			@(negedge clk);
			n++;
		end
		check(n < 900, 1'b1);
	endtask : wait_for
	task automatic convert(input logic [15:0] v);
		wait_for(1'b0);
		sample_data = v;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
	endtask : convert
	task automatic t_abort;
		wait_for(1'b0);
		abort = 1'b1;
		@(negedge clk);
		abort = 1'b0;
		repeat (20) @(negedge clk);
		check(start_ready, 1'b0);
		check(out_valid, 1'b0);
		convert(16'hBEEF);
		repeat (50) @(negedge clk);
		check(pins.busy_n, 1'b0);
		check(out_valid, 1'b0);
		check(pins.result_bus_i, 16'h0000);
		abort = 1'b1;
		@(negedge clk);
		abort = 1'b0;
		repeat (10) @(negedge clk);
		check(pins.busy_n, 1'b1);
		wait_for(1'b0);
		check(out_valid, 1'b0);
		convert(16'h0F0F);
		wait_for(1'b1);
		check(pins.busy_n, 1'b1);
		check(out_data, 16'h0F0F);
		@(negedge clk);
	endtask : t_abort
	task automatic t_codes;
		logic [15:0] c [5];
		c = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000, 16'h3C5A};
		foreach (c[i]) begin
			convert(c[i]);
			wait_for(1'b1);
			check(out_data, c[i]);
			check(pins.result_bus_oe, 1'b1);
			check(pins.result_bus_i, pins.half_sel ? c[i][15:8] : c[i][7:0]);
			@(negedge clk);
		end
	endtask : t_codes
	task automatic t_stall;
		out_ready = 1'b0;
		convert(16'h1357);
		convert(16'hA5C3);
		repeat (450) @(negedge clk);
		check(start_ready, 1'b1);
		out_ready = 1'b1;
		check(out_data, 16'h1357);
		@(negedge clk);
		check(out_data, 16'hA5C3);
		@(negedge clk);
		check(out_valid, 1'b0);
	endtask : t_stall
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		arst_n = 1'b0;
		start = 1'b0;
		abort = 1'b0;
		out_ready = 1'b1;
		sample_data = 16'h0000;
		last_bus = 8'h00;
		fail_count = 0;
		comparisons = 0;
		repeat (3) @(negedge clk);
		arst_n = 1'b1;
		t_abort;
		t_codes;
		t_stall;
		tally_and_finish;
	end
	initial begin
		#150000;
		fail_count++;
		tally_and_finish;
	end
endmodule : tb_sar_adc_parallel_read_convert_ctrl
`default_nettype wire
